// File: lcdp_pkg.sv
// lcdp_pkg: constants, carriers and states of the lcd host write port
// assumes: included first in compile order, imported whole by its users
package lcdp_pkg;

   // register byte offsets on the axi4-lite slave
   localparam int          LCDP_ADDR_W      = 4;
   localparam logic [3:0]  LCDP_OFS_CTRL    = 4'h0;
   localparam logic [3:0]  LCDP_OFS_STAT    = 4'h4;
   localparam logic [3:0]  LCDP_OFS_LAST    = 4'h8;
   localparam logic [3:0]  LCDP_OFS_CNT     = 4'hC;

   // field positions
   localparam int          LCDP_CTRL_EN     = 0;
   localparam int          LCDP_STAT_STYLE  = 0;
   localparam int          LCDP_STAT_PAR    = 1;
   localparam int          LCDP_STAT_WIDE   = 2;
   localparam int          LCDP_STAT_NIBP   = 3;
   localparam int          LCDP_STAT_OSC    = 4;
   localparam int          LCDP_SDI_BIT     = 7;
   localparam int          LCDP_SCLK_BIT    = 6;

   // reset values and codes
   localparam logic        LCDP_CTRL_EN_RST = 1'b1;
   localparam logic [1:0]  LCDP_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  LCDP_RESP_SLVERR = 2'h2;
   localparam logic [2:0]  LCDP_SER_LAST    = 3'h7;
   localparam logic        LCDP_STYLE_68    = 1'b0;
   localparam logic        LCDP_STYLE_80    = 1'b1;
   localparam logic        LCDP_SEL_CMD     = 1'b0;
   localparam logic        LCDP_SEL_DATA    = 1'b1;
   localparam int          LCDP_CNT_W       = 16;

   // host pins as sampled
   typedef struct packed {
      logic       cs_n;
      logic       sel;
      logic       strobe;
      logic [7:0] bus;
      logic       init;
      logic       par;
      logic       wide;
      logic       osc;
   } lcdp_pins_t;

   // one decoded byte
   typedef struct packed {
      logic       is_data;
      logic [7:0] data;
   } lcdp_byte_t;

   typedef enum logic [1:0] {
      LCDP_NIB_HI = 2'b01,
      LCDP_NIB_LO = 2'b10
   } lcdp_nib_t;

endpackage

// File: lcdp_sync.sv
// lcdp_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to clk; each bit is an independent level
module lcdp_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule // lcdp_sync

// File: lcdp_host_port.sv
// lcdp_host_port: write-only host port, parallel 68/80 style or serial
// assumes: pins asynchronous to clk and slower than it; axi4-lite master
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
module lcdp_host_port
   import lcdp_pkg::*;
#(
   parameter int ADDR_W = LCDP_ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire lcdp_pins_t        pins,
   output lcdp_byte_t             out_byte,
   output logic                   out_valid,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == LCDP_OFS_CTRL) || (a == LCDP_OFS_STAT) ||
                 (a == LCDP_OFS_LAST) || (a == LCDP_OFS_CNT);
   endfunction

   lcdp_pins_t            p_s;
   lcdp_pins_t            p_d;
   logic                  style_r;
   logic                  ctrl_en_r;
   logic [7:0]            shift_r;
   logic [2:0]            bit_cnt_r;
   lcdp_nib_t             nib_r;
   logic [3:0]            hi_r;
   lcdp_byte_t            last_r;
   logic [LCDP_CNT_W-1:0] cnt_r;

   // pin sampling
   lcdp_sync #(.W($bits(lcdp_pins_t))) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (pins),
      .q   (p_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         p_d <= '0;
      end else begin
         p_d <= p_s;
      end
   end

   // edge and event decoding
   wire init_edge = p_s.init ^ p_d.init;
   wire sel_ok    = !p_s.cs_n && ctrl_en_r;
   wire wr_rise   = p_s.strobe && !p_d.strobe;
   wire wr_fall   = !p_s.strobe && p_d.strobe;
   wire sclk_rise = p_s.bus[LCDP_SCLK_BIT] && !p_d.bus[LCDP_SCLK_BIT];
   wire sdi       = p_d.bus[LCDP_SDI_BIT];
   wire par_stb   = (style_r == LCDP_STYLE_80) ? wr_rise : wr_fall;
   wire par_ev    = p_s.par && sel_ok && par_stb && !init_edge;
   wire ser_ev    = !p_s.par && sel_ok && sclk_rise && !init_edge;
   wire ser_done  = ser_ev && (bit_cnt_r == LCDP_SER_LAST);
   wire nib_first = par_ev && !p_s.wide && (nib_r == LCDP_NIB_HI);
   wire nib_last  = par_ev && !p_s.wide && (nib_r == LCDP_NIB_LO);
   wire par_full  = par_ev && p_s.wide;
   wire emit      = par_full || nib_last || ser_done;
   wire [7:0] shift_nxt = {shift_r[6:0], sdi};

   lcdp_byte_t emit_byte;
   assign emit_byte.is_data = p_d.sel;
   assign emit_byte.data    = ser_done ? shift_nxt :
                              nib_last ? {hi_r, p_d.bus[7:4]} :
                              p_d.bus;

   // bus style caught at the init edge
   always_ff @(posedge clk) begin
      if (rst) begin
         style_r <= LCDP_STYLE_68;
      end else if (init_edge) begin
         style_r <= p_s.init;
      end
   end

   // serial shifter
   always_ff @(posedge clk) begin
      if (rst || init_edge || p_s.cs_n) begin
         shift_r   <= 8'h00;
         bit_cnt_r <= 3'h0;
      end else if (ser_ev) begin
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // nibble pairing
   always_ff @(posedge clk) begin
      if (rst || init_edge) begin
         nib_r <= LCDP_NIB_HI;
         hi_r  <= 4'h0;
      end else if (nib_first) begin
         nib_r <= LCDP_NIB_LO;
         hi_r  <= p_d.bus[7:4];
      end else if (nib_last) begin
         nib_r <= LCDP_NIB_HI;
      end
   end

   // byte output
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_byte  <= '0;
         last_r    <= '0;
         cnt_r     <= '0;
      end else begin
         out_valid <= emit;
         if (emit) begin
            out_byte <= emit_byte;
            last_r   <= emit_byte;
            cnt_r    <= cnt_r + 16'h0001;
         end
      end
   end

   // axi4-lite write channel
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                  !s_axi_awready;
   wire wr_ctrl = s_axi_awready && (s_axi_awaddr == LCDP_OFS_CTRL) &&
                  s_axi_wstrb[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= LCDP_RESP_OKAY;
         ctrl_en_r     <= LCDP_CTRL_EN_RST;
      end else begin
         s_axi_awready <= wr_take;
         s_axi_wready  <= wr_take;
         if (wr_ctrl) begin
            ctrl_en_r <= s_axi_wdata[LCDP_CTRL_EN];
         end
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(s_axi_awaddr) ? LCDP_RESP_OKAY :
                                                     LCDP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read channel
   wire rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

   logic [31:0] stat_word;
   logic [31:0] rd_word;
   always_comb begin
      stat_word                  = 32'h0000_0000;
      stat_word[LCDP_STAT_STYLE] = style_r;
      stat_word[LCDP_STAT_PAR]   = p_s.par;
      stat_word[LCDP_STAT_WIDE]  = p_s.wide;
      stat_word[LCDP_STAT_NIBP]  = (nib_r == LCDP_NIB_LO);
      stat_word[LCDP_STAT_OSC]   = p_s.osc;
   end
   assign rd_word = (s_axi_araddr == LCDP_OFS_CTRL) ?
                       {31'h0000_0000, ctrl_en_r} :
                    (s_axi_araddr == LCDP_OFS_STAT) ? stat_word :
                    (s_axi_araddr == LCDP_OFS_LAST) ? {23'h00_0000, last_r} :
                    (s_axi_araddr == LCDP_OFS_CNT) ? {16'h0000, cnt_r} :
                    32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= LCDP_RESP_OKAY;
      end else begin
         s_axi_arready <= rd_take;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= addr_hit(s_axi_araddr) ? LCDP_RESP_OKAY :
                                                     LCDP_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_eighth;
      ser_ev && bit_cnt_r == LCDP_SER_LAST;
   endsequence
   sequence s_byte_out(logic k);
      out_valid && out_byte.is_data == k;
   endsequence

   a_desel_no_byte: assert property (
      p_s.cs_n |=> !out_valid)
      else $error("byte delivered while deselected");
   a_desel_clears: assert property (
      p_s.cs_n |=> bit_cnt_r == 3'h0 && shift_r == 8'h00)
      else $error("serial state not cleared on deselect");
   a_init_style: assert property (
      init_edge |=> style_r == $past(p_s.init) && nib_r == LCDP_NIB_HI)
      else $error("style not latched at init edge");
   a_wr80_take: assert property (
      par_full && style_r == LCDP_STYLE_80 |->
         wr_rise ##1 out_valid && out_byte.data == $past(p_d.bus))
      else $error("80-style byte not taken at strobe rise");
   a_e68_take: assert property (
      par_ev && style_r == LCDP_STYLE_68 |-> wr_fall && !p_s.strobe)
      else $error("68-style transfer not on enable fall");
   a_serial_byte: assert property (
      s_eighth |=> s_byte_out($past(p_d.sel)) and
                  out_byte.data == $past(shift_nxt))
      else $error("eighth serial clock did not deliver byte");
   a_nib_hold: assert property (
      nib_first |=> !out_valid && nib_r == LCDP_NIB_LO)
      else $error("byte delivered after first nibble");
   a_nib_join: assert property (
      nib_first ##1 (!nib_last && !init_edge)[*1] ##[0:1000] nib_last |=>
         out_valid && out_byte.data[3:0] == $past(p_d.bus[7:4]) &&
         out_byte.data[7:4] == $past(hi_r))
      else $error("nibbles not joined upper first");
   a_mode_gate: assert property (
      out_valid && !$past(p_s.par) |-> $past(ser_done))
      else $error("parallel byte accepted in serial mode");

endmodule // lcdp_host_port

// File: lcdp_host_model.sv
// lcdp_host_model: behavioural mcu writing the host port pins
// assumes: clk is the port clock; the bench calls the tasks
module lcdp_host_model
   import lcdp_pkg::*;
(
   input  wire logic clk,
   output lcdp_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic style_r;
   initial begin
      pins = '0;
      pins.cs_n = 1'b1;
      pins.osc = 1'b1;
      pins.par = 1'b1;
      pins.wide = 1'b1;
      style_r = LCDP_STYLE_68;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // two toggles so an edge is always seen
   task automatic init(input logic lvl);
      pins.cs_n <= 1'b1;
      pins.strobe <= lvl;
      pins.init <= ~lvl;
      hold(6);
      pins.init <= lvl;
      style_r = lvl;
      hold(6);
   endtask
   task automatic pulse(input logic [7:0] b);
      pins.bus <= b;
      hold(4);
      pins.strobe <= (style_r == LCDP_STYLE_68);
      hold(4);
      pins.strobe <= (style_r == LCDP_STYLE_80);
      hold(2);
      pins.bus <= ~b;
      hold(2);
   endtask
   task automatic par_wr(input logic cs, input logic sel,
                         input logic [7:0] d, input logic wide);
      pins.par <= 1'b1;
      pins.wide <= wide;
      pins.sel <= sel;
      pins.cs_n <= ~cs;
      if (wide) begin
         pulse(d);
      end else begin
         pulse({d[7:4], ~d[3:0]});
         pulse({d[3:0], d[7:4]});
      end
      pins.cs_n <= 1'b1;
      hold(4);
   endtask
   // shift clock is 8 cycles (64 ns), still outside frames
   task automatic ser_wr(input logic sel, input logic [7:0] d, input int n);
      pins.par <= 1'b0;
      pins.bus[6] <= 1'b0;
      pins.cs_n <= 1'b0;
      pins.sel <= ~sel;
      for (int i = 7; i > 7 - n; i--) begin
         pins.bus[7] <= d[i];
         if (i == 0) pins.sel <= sel;
         hold(4);
         pins.bus[6] <= 1'b1;
         hold(4);
         pins.bus[6] <= 1'b0;
      end
      hold(4);
      pins.cs_n <= 1'b1;
      pins.bus[7] <= ~pins.bus[7];
      hold(4);
   endtask
endmodule // lcdp_host_model

// File: lcdp_host_port_test.sv
// lcdp_host_port_test: self-checking bench of the host write port
// assumes: lcdp_pkg, lcdp_sync, lcdp_host_port, lcdp_host_model compiled
module lcdp_host_port_test
   import lcdp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk;
   logic              rst;
   lcdp_pins_t        pins;
   lcdp_byte_t        out_byte;
   logic              out_valid;
   logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic              s_axi_rready;
   logic [7:0]        d;
   lcdp_byte_t        q[$];
   lcdp_byte_t        last_e;
   int                error_cnt = 0, n_checks = 0, cyc = 0, exp_cnt = 0;
   int                seed;
   lcdp_host_model lcdp_host_model_i (.clk, .pins);
   lcdp_host_port lcdp_host_port_i (.clk, .rst, .pins, .out_byte,
      .out_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (out_valid === 1'b1) q.push_back(out_byte);
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   function automatic lcdp_byte_t mk_byte(input logic s, input logic [7:0] v);
      mk_byte.is_data = (s == LCDP_SEL_DATA);
      mk_byte.data = v;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic exp_byte(input logic s, input logic [7:0] v);
      last_e = mk_byte(s, v);
      exp_cnt++;
      for (int i = 0; i < 40 && q.size() == 0; i++) @(posedge clk);
      chk(32'(q.size()), 32'h0000_0001);
      if (q.size() != 0) chk(32'(q.pop_front()), 32'(last_e));
   endtask
   task automatic exp_none();
      repeat (12) @(posedge clk);
      chk(32'(q.size()), 32'h0000_0000);
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(rd & m, e);
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      seed = 32'h6024;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rchk(LCDP_OFS_CTRL, 32'h0000_0001, 32'(LCDP_CTRL_EN_RST),
           LCDP_RESP_OKAY);
      rchk(4'h2, 32'h0000_0000, 32'h0000_0000, LCDP_RESP_SLVERR);
      axw(4'h6, 32'h0000_0001);
      chk(32'(rs), 32'(LCDP_RESP_SLVERR));
      lcdp_host_model_i.init(LCDP_STYLE_80);
      rchk(LCDP_OFS_STAT, 32'h0000_001F, 32'h0000_0017,
           LCDP_RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         lcdp_host_model_i.par_wr(1'b1, i[0], d, 1'b1);
         exp_byte(i[0], d);
      end
      lcdp_host_model_i.par_wr(1'b0, 1'b1, 8'hA5, 1'b1);
      exp_none();
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         lcdp_host_model_i.par_wr(1'b1, i[0], d, 1'b0);
         exp_byte(i[0], d);
      end
      lcdp_host_model_i.init(LCDP_STYLE_68);
      rchk(LCDP_OFS_STAT, 32'h0000_0001, 32'h0000_0000, LCDP_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         lcdp_host_model_i.par_wr(1'b1, i[0], d, 1'b1);
         exp_byte(i[0], d);
      end
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         lcdp_host_model_i.ser_wr(i[0], d, 8);
         exp_byte(i[0], d);
      end
      lcdp_host_model_i.ser_wr(1'b1, 8'hFF, 3);
      exp_none();
      lcdp_host_model_i.ser_wr(1'b0, 8'h5A, 8);
      exp_byte(1'b0, 8'h5A);
      axw(LCDP_OFS_CTRL, 32'h0000_0000);
      chk(32'(rs), 32'(LCDP_RESP_OKAY));
      lcdp_host_model_i.par_wr(1'b1, 1'b0, 8'h3C, 1'b1);
      exp_none();
      axw(LCDP_OFS_CTRL, 32'h0000_0001);
      rchk(LCDP_OFS_CNT, 32'h0000_FFFF, 32'(exp_cnt), LCDP_RESP_OKAY);
      rchk(LCDP_OFS_LAST, 32'h0000_01FF, 32'(last_e), LCDP_RESP_OKAY);
      end_sim();
   end
endmodule // lcdp_host_port_test
